// ==== core/pat_top.sv ====
// Pulse accumulator: pin edge detection, event and gated counting, flags and requests.
// Assumes a one-clock register port; read data stand in the cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
`include "pat_defines.svh"

module pat_top #(
    parameter int COUNT_W = `PAT_DATA_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic pulse_input_pin_i,
    input wire logic cpu_int_mask_i,
    input wire logic [`PAT_ADDR_W-1:0] reg_addr_i,
    input wire logic [`PAT_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [`PAT_DATA_W-1:0] reg_rdata_o,
    output logic irq_o,
    output logic irq_overflow_o,
    output logic irq_pin_o,
    output pat_pkg::pat_mode_type mode_o
);
    import pat_pkg::*;

    initial begin
        if (COUNT_W < 1 || COUNT_W > `PAT_DATA_W) begin
            $error("pat_top: COUNT_W must be 1 to 8");
        end
    end

    pat_ctl_if ctl ();

    pat_edge_det u_edge_det (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .pin_i(pulse_input_pin_i),
        .ctl(ctl.det)
    );

    pat_tick_gen u_tick_gen (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ctl(ctl.tick_src)
    );

    // Register state: control, counter, sticky flags and read data
    logic [`PAT_DATA_W-1:0] ctrl_q, ctrl_d;
    logic [COUNT_W-1:0] count_q, count_d;
    logic pin_edge_flag_q, pin_edge_flag_d;
    logic counter_overflow_flag_q, counter_overflow_flag_d;
    logic [`PAT_DATA_W-1:0] rdata_q, rdata_d;

    // Decoded fields
    logic accum_enable;
    pat_mode_type mode;
    logic edge_select_bit;
    logic pin_interrupt_enable;
    logic overflow_interrupt_enable;
    pat_prescale_type timer_prescale_select;

    // Access decode
    logic wr_ctrl, wr_status, wr_count;
    logic count_inc;
    logic wrap;
    logic edge_clear, ovf_clear;
    logic ovf_req, pin_req;
    logic [`PAT_DATA_W-1:0] status_view;

    always_comb begin
        accum_enable = ctrl_q[`PAT_CTRL_ENABLE];
        mode = ctrl_q[`PAT_CTRL_MODE] ? PAT_MODE_GATED : PAT_MODE_EVENT;
        edge_select_bit = ctrl_q[`PAT_CTRL_EDGE];
        pin_interrupt_enable = ctrl_q[`PAT_CTRL_PIN_IE];
        overflow_interrupt_enable = ctrl_q[`PAT_CTRL_OVF_IE];
        timer_prescale_select = ctrl_q[`PAT_CTRL_PS_HI:`PAT_CTRL_PS_LO];
    end

    assign ctl.edge_sel = edge_select_bit;
    assign ctl.prescale = timer_prescale_select;

    always_comb begin
        wr_ctrl = reg_wr_i && (reg_addr_i == `PAT_ADDR_CTRL);
        wr_status = reg_wr_i && (reg_addr_i == `PAT_ADDR_STATUS);
        wr_count = reg_wr_i && (reg_addr_i == `PAT_ADDR_COUNT);
    end

    // Counter: event steps on each accepted edge, gated steps on the tick while active
    always_comb begin
        count_inc = 1'b0;
        if (accum_enable) begin
            case (mode)
                PAT_MODE_EVENT: begin
                    count_inc = ctl.edge_pulse;
                end
                PAT_MODE_GATED: begin
                    count_inc = ctl.tick && ctl.pin_active;
                end
                default: begin
                    count_inc = 1'b0;
                end
            endcase
        end
        wrap = count_inc && (count_q == {COUNT_W{1'b1}});
        count_d = count_q;
        // A software write owns the cycle; an increment landing on it is dropped
        if (wr_count) begin
            count_d = reg_wdata_i[COUNT_W-1:0];
        end else if (count_inc) begin
            count_d = count_q + 1'b1;
        end
    end

    // Sticky flags; a set in the clearing cycle wins over the clear
    always_comb begin
        edge_clear = wr_status && reg_wdata_i[`PAT_STAT_EDGE];
        ovf_clear = wr_status && reg_wdata_i[`PAT_STAT_OVF];
        // Edge flag is set in either mode and even with counting disabled
        pin_edge_flag_d = (pin_edge_flag_q && !edge_clear) || ctl.edge_pulse;
        counter_overflow_flag_d = (counter_overflow_flag_q && !ovf_clear)
            || (wrap && !wr_count);
    end

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = reg_wdata_i & `PAT_CTRL_MASK;
        end
    end

    always_comb begin
        status_view = '0;
        status_view[`PAT_STAT_EDGE] = pin_edge_flag_q;
        status_view[`PAT_STAT_OVF] = counter_overflow_flag_q;
    end

    // Read data valid only in the cycle after the strobe; unmapped reads give zero
    always_comb begin
        rdata_d = `PAT_READ_IDLE;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `PAT_ADDR_CTRL: begin
                    rdata_d = ctrl_q;
                end
                `PAT_ADDR_STATUS: begin
                    rdata_d = status_view;
                end
                `PAT_ADDR_COUNT: begin
                    rdata_d = `PAT_DATA_W'(count_q);
                end
                `PAT_ADDR_PIN: begin
                    rdata_d = `PAT_READ_IDLE;
                    rdata_d[`PAT_PIN_LEVEL] = ctl.pin_level;
                end
                default: begin
                    rdata_d = `PAT_READ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_q <= `PAT_CTRL_RESET;
            count_q <= COUNT_W'(`PAT_COUNT_RESET);
            pin_edge_flag_q <= 1'b0;
            counter_overflow_flag_q <= 1'b0;
            rdata_q <= `PAT_READ_IDLE;
        end else begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            pin_edge_flag_q <= pin_edge_flag_d;
            counter_overflow_flag_q <= counter_overflow_flag_d;
            rdata_q <= rdata_d;
        end
    end

    // Requests: local enables, then the global mask, overflow first
    always_comb begin
        ovf_req = counter_overflow_flag_q && overflow_interrupt_enable;
        pin_req = pin_edge_flag_q && pin_interrupt_enable;
        irq_overflow_o = ovf_req && !cpu_int_mask_i;
        // Pin request waits while an overflow is pending so overflow is serviced first
        irq_pin_o = pin_req && !ovf_req && !cpu_int_mask_i;
        irq_o = (ovf_req || pin_req) && !cpu_int_mask_i;
    end

    assign reg_rdata_o = rdata_q;
    assign mode_o = mode;

endmodule // pat_top

`default_nettype wire

// ==== core/pat_defines.svh ====
// Register map, field positions, reset values and timing counts of the pulse accumulator.
// Assumes an 8-bit register port with a 4-bit word address.
`ifndef PAT_DEFINES_SVH
`define PAT_DEFINES_SVH

`define PAT_ADDR_W 4
`define PAT_DATA_W 8

`define PAT_ADDR_CTRL 4'h0
`define PAT_ADDR_STATUS 4'h1
`define PAT_ADDR_COUNT 4'h2
`define PAT_ADDR_PIN 4'h3

`define PAT_CTRL_ENABLE 0
`define PAT_CTRL_MODE 1
`define PAT_CTRL_EDGE 2
`define PAT_CTRL_PIN_IE 3
`define PAT_CTRL_OVF_IE 4
`define PAT_CTRL_PS_LO 5
`define PAT_CTRL_PS_HI 6
`define PAT_CTRL_MASK 8'h7f

`define PAT_STAT_EDGE 0
`define PAT_STAT_OVF 1

`define PAT_PIN_LEVEL 0

`define PAT_CTRL_RESET 8'h00
`define PAT_COUNT_RESET 8'h00
`define PAT_READ_IDLE 8'h00

`define PAT_GATE_DIVIDE 64
`define PAT_LOCKOUT_CYCLES 2

`define PAT_TIMER_W 8
`define PAT_PRE_W 4
`define PAT_PS_DIV0 4'h0
`define PAT_PS_DIV1 4'h3
`define PAT_PS_DIV2 4'h7
`define PAT_PS_DIV3 4'hf
`define PAT_TAP0 3'h5
`define PAT_TAP1 3'h3
`define PAT_TAP2 3'h2
`define PAT_TAP3 3'h1

`endif

// ==== core/pat_pkg.sv ====
// Types shared by the pulse accumulator modules.
// Assumes nothing beyond the defines header for numbers.
package pat_pkg;

    typedef enum logic {
        PAT_MODE_EVENT,
        PAT_MODE_GATED
    } pat_mode_type;

    typedef enum logic {
        PAT_DET_ARMED,
        PAT_DET_HOLD
    } pat_det_state_type;

    typedef logic [1:0] pat_prescale_type;

endpackage

// ==== core/pat_ctl_if.sv ====
// Signals passed between the pulse accumulator core and its two helpers.
// Assumes all users run on the same reference clock.
`timescale 1ns/100ps
`default_nettype none

interface pat_ctl_if;
    import pat_pkg::*;

    logic edge_sel;
    pat_prescale_type prescale;
    logic edge_pulse;
    logic pin_level;
    logic pin_active;
    logic tick;

    modport det (
        input edge_sel,
        output edge_pulse,
        output pin_level,
        output pin_active
    );

    modport tick_src (
        input prescale,
        output tick
    );

    modport core (
        output edge_sel,
        output prescale,
        input edge_pulse,
        input pin_level,
        input pin_active,
        input tick
    );

endinterface

`default_nettype wire

// ==== core/pat_edge_det.sv ====
// Pin synchroniser and edge detector with a two-cycle lockout.
// Assumes the pin is asynchronous; each reference clock stands for one bus cycle.
`timescale 1ns/100ps
`default_nettype none
`include "pat_defines.svh"

module pat_edge_det (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    pat_ctl_if.det ctl
);
    import pat_pkg::*;

    logic sync1_q, sync1_d;
    logic sync2_q, sync2_d;
    logic prev_q, prev_d;
    logic pulse_q, pulse_d;
    logic [1:0] hold_q, hold_d;
    pat_det_state_type state_q, state_d;
    logic seen;

    always_comb begin
        sync1_d = pin_i;
        sync2_d = sync1_q;
        prev_d = sync2_q;
        // Rising when edge select is set, falling otherwise
        seen = ctl.edge_sel ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
        pulse_d = 1'b0;
        state_d = state_q;
        hold_d = hold_q;
        case (state_q)
            PAT_DET_ARMED: begin
                if (seen) begin
                    pulse_d = 1'b1;
                    state_d = PAT_DET_HOLD;
                    hold_d = 2'((`PAT_LOCKOUT_CYCLES) - 1);
                end
            end
            PAT_DET_HOLD: begin
                // Edges inside the lockout are dropped, not deferred
                hold_d = hold_q - 2'h1;
                if (hold_q == 2'h1) begin
                    state_d = PAT_DET_ARMED;
                end
            end
            default: begin
                state_d = PAT_DET_ARMED;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        sync1_q <= sync1_d;
        sync2_q <= sync2_d;
        if (rst_i) begin
            // Track the synchronised pin through reset so a high pin gives no false edge
            prev_q <= prev_d;
            pulse_q <= 1'b0;
            hold_q <= 2'h0;
            state_q <= PAT_DET_ARMED;
        end else begin
            prev_q <= prev_d;
            pulse_q <= pulse_d;
            hold_q <= hold_d;
            state_q <= state_d;
        end
    end

    assign ctl.edge_pulse = pulse_q;
    assign ctl.pin_level = sync2_q;
    // Active level is the one opposite to the detected trailing edge
    assign ctl.pin_active = sync2_q ^ ctl.edge_sel;

endmodule // pat_edge_det

`default_nettype wire

// ==== core/pat_tick_gen.sv ====
// Free-running timer prescaler chain and the divide-by-64 gating tick tap.
// Assumes prescale select is static in normal use; a change restarts the prescaler.
`timescale 1ns/100ps
`default_nettype none
`include "pat_defines.svh"

module pat_tick_gen #(
    parameter int TIMER_W = `PAT_TIMER_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    pat_ctl_if.tick_src ctl
);
    import pat_pkg::*;

    initial begin
        if (TIMER_W < 6) begin
            $error("pat_tick_gen: TIMER_W must be at least 6");
        end
    end

    logic [`PAT_PRE_W-1:0] pre_q, pre_d;
    logic [TIMER_W-1:0] timer_q, timer_d;
    pat_prescale_type ps_q, ps_d;
    logic tap_q, tap_d;
    logic [`PAT_PRE_W-1:0] pre_last;
    logic [2:0] tap_idx;

    always_comb begin
        case (ctl.prescale)
            2'h0: begin
                pre_last = `PAT_PS_DIV0;
                tap_idx = `PAT_TAP0;
            end
            2'h1: begin
                pre_last = `PAT_PS_DIV1;
                tap_idx = `PAT_TAP1;
            end
            2'h2: begin
                pre_last = `PAT_PS_DIV2;
                tap_idx = `PAT_TAP2;
            end
            default: begin
                pre_last = `PAT_PS_DIV3;
                tap_idx = `PAT_TAP3;
            end
        endcase
        ps_d = ctl.prescale;
        timer_d = timer_q;
        if (ps_q != ctl.prescale || pre_q == pre_last) begin
            pre_d = '0;
        end else begin
            pre_d = pre_q + 1'b1;
        end
        if (pre_q == pre_last) begin
            timer_d = timer_q + 1'b1;
        end
        // Tap moves with the prescale so the tick period stays 64 bus cycles
        tap_d = timer_q[tap_idx];
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pre_q <= '0;
            timer_q <= '0;
            ps_q <= 2'h0;
            tap_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            timer_q <= timer_d;
            ps_q <= ps_d;
            tap_q <= tap_d;
        end
    end

    // One-cycle pulse on each rising edge of the tap bit
    assign ctl.tick = tap_d & ~tap_q;

endmodule // pat_tick_gen

`default_nettype wire

// ==== sim/pat_pin_model.sv ====
// Behavioural pulse source on the accumulator's input pin.
// Assumes the bench commands level, run and half period on the same clock.
`timescale 1ns/100ps
`default_nettype none

module pat_pin_model (
    input wire logic ref_clk_i,
    input wire logic go_i,
    input wire logic level_i,
    input wire logic [3:0] half_i,
    output logic pin_o
);
    logic [3:0] cnt_q;
    initial pin_o = 1'b0;
    initial cnt_q = 4'h0;
    // Even at half = 1, like edges stay two cycles apart
    always @(posedge ref_clk_i) begin
        if (!go_i) begin
            pin_o <= level_i;
            cnt_q <= 4'h0;
        end else if (cnt_q + 4'h1 >= half_i) begin
            pin_o <= ~pin_o;
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // pat_pin_model

`default_nettype wire

// ==== sim/pat_top_assertions.sv ====
// Port-level checks of the pulse accumulator.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "pat_defines.svh"

module pat_top_assertions
    import pat_pkg::*;
#(
    parameter int COUNT_W = `PAT_DATA_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic pulse_input_pin_i,
    input wire logic cpu_int_mask_i,
    input wire logic [`PAT_ADDR_W-1:0] reg_addr_i,
    input wire logic [`PAT_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`PAT_DATA_W-1:0] reg_rdata_o,
    input wire logic irq_o,
    input wire logic irq_overflow_o,
    input wire logic irq_pin_o,
    input wire pat_pkg::pat_mode_type mode_o
);
    // Shadow of the control register, rebuilt from observed writes
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    always_comb begin
        ctrl_d = ctrl_q;
        if (reg_wr_i && reg_addr_i == `PAT_ADDR_CTRL) begin
            ctrl_d = reg_wdata_i;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        ctrl_q <= rst_i ? `PAT_CTRL_RESET : ctrl_d;
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ctrl_wr;
        reg_wr_i && reg_addr_i == `PAT_ADDR_CTRL;
    endsequence
    sequence s_ctrl_rd;
        reg_rd_i && reg_addr_i == `PAT_ADDR_CTRL;
    endsequence
    sequence s_pin_steady;
        $stable(pulse_input_pin_i) [*4];
    endsequence

    a_irq_sum: assert property (irq_o == (irq_overflow_o || irq_pin_o))
        else $error("combined request differs from its parts");
    a_mask_gates: assert property (cpu_int_mask_i |-> !irq_o && !irq_pin_o)
        else $error("request seen while globally masked");
    a_ovf_priority: assert property (irq_overflow_o |-> !irq_pin_o)
        else $error("pin request beside overflow request");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside its cycle");
    a_mode_follows: assert property (s_ctrl_wr |=>
        mode_o == ($past(reg_wdata_i[`PAT_CTRL_MODE]) ? PAT_MODE_GATED : PAT_MODE_EVENT))
        else $error("mode not taken from control write");
    a_ctrl_readback: assert property (s_ctrl_wr ##1 !reg_wr_i ##1 s_ctrl_rd |=>
        reg_rdata_o == ($past(reg_wdata_i, 3) & `PAT_CTRL_MASK))
        else $error("control readback wrong");
    a_pin_ie_gate: assert property (irq_pin_o |-> ctrl_q[`PAT_CTRL_PIN_IE])
        else $error("pin request while locally disabled");
    a_ovf_ie_gate: assert property (irq_overflow_o |-> ctrl_q[`PAT_CTRL_OVF_IE])
        else $error("overflow request while disabled");
    a_pin_read: assert property (s_pin_steady ##0
        (reg_rd_i && reg_addr_i == `PAT_ADDR_PIN) |=>
        reg_rdata_o == {7'h00, $past(pulse_input_pin_i)})
        else $error("pin level readback wrong");
endmodule // pat_top_assertions

bind pat_top pat_top_assertions #(.COUNT_W(COUNT_W)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pulse_input_pin_i(pulse_input_pin_i),
    .cpu_int_mask_i(cpu_int_mask_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .irq_overflow_o(irq_overflow_o), .irq_pin_o(irq_pin_o), .mode_o(mode_o)
);

`default_nettype wire

// ==== sim/pat_top_test.sv ====
// Self-checking bench of the pulse accumulator with a pin model.
// Assumes the register port answers one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
`include "pat_defines.svh"

module pat_top_test;
    import pat_pkg::*;
    logic ref_clk_i, rst_i, go, lvl, pin, mask, wr_s, rd_s, irq, irq_ovf, irq_pin;
    logic [3:0] half, addr;
    logic [7:0] wdata, rdata, v;
    pat_mode_type mode;
    int mismatches = 0;
    int checks_done = 0;
    int n, h, k;

    pat_pin_model u_pin (.ref_clk_i(ref_clk_i), .go_i(go), .level_i(lvl), .half_i(half),
        .pin_o(pin));
    pat_top u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .pulse_input_pin_i(pin),
        .cpu_int_mask_i(mask), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_rdata_o(rdata), .irq_o(irq), .irq_overflow_o(irq_ovf),
        .irq_pin_o(irq_pin), .mode_o(mode));

    initial begin
        ref_clk_i = 1'b0;
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk_i);
        wr_s <= 1'b0;
    endtask

    task automatic rc(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk_i);
        rd_s <= 1'b0;
        @(negedge ref_clk_i);
        chk(rdata, exp);
    endtask

    task automatic wait_n(input int c);
        repeat (c) @(posedge ref_clk_i);
    endtask

    // Odd toggle counts only, so the pin is left at the inverse level
    task automatic run(input int t, input int hp);
        @(posedge ref_clk_i);
        half <= 4'(hp);
        go <= 1'b1;
        wait_n(t * hp);
        go <= 1'b0;
        lvl <= ~lvl;
        wait_n(8);
    endtask

    task automatic pin_low;
        @(posedge ref_clk_i);
        lvl <= 1'b0;
        wait_n(8);
    endtask

    initial begin
        rst_i = 1'b1;
        {go, lvl, mask, wr_s, rd_s} = 5'h00;
        half = 4'h1;
        addr = 4'h0;
        wdata = 8'h00;
        void'($urandom(36));
        wait_n(4);
        rst_i <= 1'b0;
        rc(`PAT_ADDR_CTRL, `PAT_CTRL_RESET);
        rc(`PAT_ADDR_STATUS, 8'h00);
        rc(`PAT_ADDR_COUNT, `PAT_COUNT_RESET);
        wr(4'h7, 8'hff);
        rc(4'h7, `PAT_READ_IDLE);
        v = 8'($urandom);
        wr(`PAT_ADDR_CTRL, v);
        rc(`PAT_ADDR_CTRL, v & `PAT_CTRL_MASK);
        for (int i = 1; i >= 0; i--) begin
            @(posedge ref_clk_i);
            lvl <= i[0];
            wait_n(6);
            rc(`PAT_ADDR_PIN, {7'h00, i[0]});
        end
        for (int e = 0; e < 2; e++) begin
            pin_low();
            wr(`PAT_ADDR_CTRL, 8'h01 | 8'(e << `PAT_CTRL_EDGE));
            wr(`PAT_ADDR_COUNT, 8'h00);
            wr(`PAT_ADDR_STATUS, 8'h03);
            n = $urandom_range(40, 3);
            h = (e == 0) ? 1 : $urandom_range(4, 2);
            run(2 * n - 1, h);
            rc(`PAT_ADDR_COUNT, 8'((e == 1) ? n : n - 1));
            rc(`PAT_ADDR_STATUS, 8'h01);
        end
        pin_low();
        wr(`PAT_ADDR_CTRL, 8'h1d);
        wr(`PAT_ADDR_STATUS, 8'h03);
        wr(`PAT_ADDR_COUNT, 8'hfe);
        run(3, 2);
        rc(`PAT_ADDR_COUNT, 8'h00);
        rc(`PAT_ADDR_STATUS, 8'h03);
        chk({5'h00, irq, irq_ovf, irq_pin}, 8'h06);
        @(posedge ref_clk_i);
        mask <= 1'b1;
        @(negedge ref_clk_i);
        chk({5'h00, irq, irq_ovf, irq_pin}, 8'h00);
        @(posedge ref_clk_i);
        mask <= 1'b0;
        wr(`PAT_ADDR_STATUS, 8'h02);
        @(negedge ref_clk_i);
        chk({5'h00, irq, irq_ovf, irq_pin}, 8'h05);
        wr(`PAT_ADDR_STATUS, 8'h00);
        rc(`PAT_ADDR_STATUS, 8'h01);
        wr(`PAT_ADDR_STATUS, 8'h01);
        rc(`PAT_ADDR_STATUS, 8'h00);
        pin_low();
        for (int p = 0; p < 4; p++) begin
            wr(`PAT_ADDR_CTRL, 8'h03 | 8'(p << `PAT_CTRL_PS_LO));
            wr(`PAT_ADDR_COUNT, 8'h00);
            wr(`PAT_ADDR_STATUS, 8'h03);
            k = $urandom_range(4, 2);
            @(posedge ref_clk_i);
            lvl <= 1'b1;
            wait_n(`PAT_GATE_DIVIDE * k);
            lvl <= 1'b0;
            wait_n(8);
            rc(`PAT_ADDR_COUNT, 8'(k));
            rc(`PAT_ADDR_STATUS, 8'h01);
            wait_n(100);
            rc(`PAT_ADDR_COUNT, 8'(k));
        end
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        wait_n(4);
        rst_i <= 1'b0;
        rc(`PAT_ADDR_COUNT, `PAT_COUNT_RESET);
        rc(`PAT_ADDR_CTRL, `PAT_CTRL_RESET);
        results();
    end

    // Whole run needs well under 5000 cycles
    initial begin
        wait_n(20000);
        mismatches++;
        results();
    end
endmodule // pat_top_test

`default_nettype wire
